// >>> hw/sdm_mode_read_sref.sv
// device side: mode register read path, self-refresh, bank masking, calibration reads
`default_nettype none
module sdm_mode_read_sref
    import sdm_pkg::*;
#(
    parameter int RL = RL_DEFAULT,
    parameter int LANES = 4,
    parameter int TSI_CYCLES = TSI_CYC
)(
    input wire logic CLOCK,
    input wire logic RST,
    input wire sdm_ca_t CMD,
    output sdm_dq_t DQ_BUS,
    output logic [31:0] REFRESH_EN,
    input wire logic [2:0] TEMP_SENSE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA
);
    localparam int LAST_PH = RL + BURST_LEN - 1;
    localparam int RLA = RL;
    localparam int XSR_HOLD = XSR_CYC - 1;

    // one data beat of a register read burst
    function automatic logic [31:0] beat_word(input sdm_kind_t kind, input logic [7:0] data,
                                              input logic [1:0] beat, input logic fill);
        logic [31:0] w;
        logic b;
        w = 32'h0000_0000;
        b = (kind == K_CAL_A) ? CAL_A_PAT[beat] : CAL_B_PAT[beat];
        if (kind == K_NORMAL && beat == 2'h0)
            w[7:0] = data;
        else if (kind == K_CAL_A || kind == K_CAL_B)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                w[l*8] = b;
                w[l*8+1 +: 7] = fill ? {7{b}} : 7'h00;
            end
        end
        return w;
    endfunction : beat_word

    logic cke_prev_q;
    sdm_pwr_t pwr_q, pwr_d;
    logic [15:0] xsr_q, xsr_d;
    logic [3:0] bank_mask_q, bank_mask_d;
    logic [7:0] seg_mask_q, seg_mask_d;
    logic [7:0] ph_q, ph_d;
    sdm_kind_t kind_q, kind_d;
    logic [7:0] rdata_q, rdata_d;
    sdm_dq_t dq_q, dq_d;
    logic [31:0] ref_q, ref_d;
    logic fill_q, fill_d;
    logic [7:0] ahb_ofs_q, ahb_ofs_d;
    logic ahb_wr_q, ahb_wr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [2:0] temp_code;
    logic cmd_take, mrr_go, mrw_go, sref_go, exit_go;
    logic [7:0] ma;
    logic [7:0] beat_idx;
    logic ahb_go;

    // command decode; reads and writes sampled only while awake, clock-enable steady and no burst pending
    always_comb
    begin
        cmd_take = (pwr_q == ST_AWAKE) && CMD.cke && cke_prev_q && !CMD.cs_n
            && (ph_q == 8'h00);
        mrr_go = cmd_take && (CMD.ca_r[3:0] == CMD_MRR);
        mrw_go = cmd_take && (CMD.ca_r[3:0] == CMD_MRW);
        ma = {CMD.ca_f[1:0], CMD.ca_r[9:4]};
        sref_go = (pwr_q == ST_AWAKE) && cke_prev_q && !CMD.cke && !CMD.cs_n
            && (CMD.ca_r[2:0] == CMD_SREF) && (ph_q == 8'h00);
        exit_go = (pwr_q == ST_SREF) && CMD.cke;
    end

    // power state and exit interval counter
    always_comb
    begin
        pwr_d = pwr_q;
        xsr_d = xsr_q;
        case (pwr_q)
            ST_AWAKE:
                if (sref_go)
                    pwr_d = ST_SREF;
            ST_SREF:
                if (exit_go)
                begin
                    pwr_d = ST_EXIT;
                    xsr_d = 16'(XSR_CYC - 1);
                end
            ST_EXIT:
                // awake one edge early so a command exactly xsr cycles after exit is taken
                if (!CMD.cke)
                    pwr_d = ST_SREF;
                else if (xsr_q <= 16'h0001)
                    pwr_d = ST_AWAKE;
                else
                    xsr_d = xsr_q - 16'h0001;
            default:
                pwr_d = ST_AWAKE;
        endcase
    end

    // mode register writes to the two mask registers; other addresses ignored
    always_comb
    begin
        bank_mask_d = bank_mask_q;
        seg_mask_d = seg_mask_q;
        if (mrw_go && ma == MA_BANK_MASK)
            bank_mask_d = CMD.ca_f[5:2];
        if (mrw_go && ma == MA_SEG_MASK)
            seg_mask_d = CMD.ca_f[9:2];
    end

    // per bank and segment refresh enables while in self-refresh
    always_comb
    begin
        ref_d = 32'h0000_0000;
        for (int b = 0; b < 4; b++)
        begin
            for (int s = 0; s < 8; s++)
                ref_d[b*8+s] = (pwr_q == ST_SREF) && !bank_mask_q[b]
                    && !seg_mask_q[s];
        end
    end

    // register read: capture selection, then count phases until the burst ends
    always_comb
    begin
        kind_d = kind_q;
        rdata_d = rdata_q;
        ph_d = ph_q;
        if (mrr_go)
        begin
            ph_d = 8'h01;
            rdata_d = 8'h00;
            kind_d = K_NORMAL;
            case (ma)
                MA_TEMP: rdata_d = {5'h00, temp_code};
                MA_BANK_MASK: rdata_d = {4'h0, bank_mask_q};
                MA_SEG_MASK: rdata_d = seg_mask_q;
                MA_CAL_A: kind_d = K_CAL_A;
                MA_CAL_B: kind_d = K_CAL_B;
                default: kind_d = K_RSVD;
            endcase
        end
        else if (ph_q == 8'(LAST_PH))
            ph_d = 8'h00;
        else if (ph_q != 8'h00)
            ph_d = ph_q + 8'h01;
    end

    // data pins are loaded one cycle ahead so they come straight from flops
    always_comb
    begin
        beat_idx = ph_q - 8'(RL - 1);
        dq_d = '0;
        if (ph_q >= 8'(RL - 1) && ph_q <= 8'(LAST_PH - 1))
        begin
            dq_d.dq = beat_word(kind_q, rdata_q, beat_idx[1:0], fill_q);
            dq_d.dq_oe = 4'((1 << LANES) - 1);
            dq_d.dqs_t = !beat_idx[0];
            dq_d.dqs_c = beat_idx[0];
            dq_d.dqs_oe = 1'b1;
        end
    end

    // bus slave: zero wait state, address phase captured, data phase acts
    always_comb
    begin
        ahb_go = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
        ahb_ofs_d = ahb_go ? HADDR[7:0] : ahb_ofs_q;
        ahb_wr_d = ahb_go && HWRITE;
        fill_d = fill_q;
        if (ahb_wr_q && ahb_ofs_q == OFS_CTRL)
            fill_d = HWDATA[CTRL_FILL_BIT];
        hrdata_d = 32'h0000_0000;
        if (ahb_go && !HWRITE)
        begin
            case (HADDR[7:0])
                OFS_CTRL: hrdata_d = {31'h0000_0000, fill_q};
                OFS_STATUS: hrdata_d = {25'h0000_000, temp_code, 1'b0, ph_q != 8'h00,
                    pwr_q == ST_EXIT, pwr_q == ST_SREF};
                OFS_MASKS: hrdata_d = {16'h0000, seg_mask_q, 4'h0, bank_mask_q};
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            cke_prev_q <= 1'b0;
            pwr_q <= ST_AWAKE;
            xsr_q <= 16'h0000;
            bank_mask_q <= BANK_MASK_RESET;
            seg_mask_q <= SEG_MASK_RESET;
            ph_q <= 8'h00;
            kind_q <= K_NORMAL;
            rdata_q <= 8'h00;
            dq_q <= '0;
            ref_q <= 32'h0000_0000;
            fill_q <= CTRL_FILL_RESET;
            ahb_ofs_q <= 8'h00;
            ahb_wr_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            cke_prev_q <= CMD.cke;
            pwr_q <= pwr_d;
            xsr_q <= xsr_d;
            bank_mask_q <= bank_mask_d;
            seg_mask_q <= seg_mask_d;
            ph_q <= ph_d;
            kind_q <= kind_d;
            rdata_q <= rdata_d;
            dq_q <= dq_d;
            ref_q <= ref_d;
            fill_q <= fill_d;
            ahb_ofs_q <= ahb_ofs_d;
            ahb_wr_q <= ahb_wr_d;
            hrdata_q <= hrdata_d;
        end
    end

    // exit from self-refresh forces a fresh temperature sample
    sdm_temp_sampler #(.TSI_CYCLES(TSI_CYCLES)) u_temp (
        .clk(CLOCK),
        .rst(RST),
        .force_sample(exit_go),
        .sensor(TEMP_SENSE),
        .temp_code(temp_code)
    );

    assign DQ_BUS = dq_q;
    assign REFRESH_EN = ref_q;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_q;

    AST_MRR_AT_RL: assert property (@(posedge CLOCK) disable iff (RST)
        mrr_go |-> !DQ_BUS.dqs_oe ##RLA DQ_BUS.dqs_oe) else $error("read data not at latency");
    AST_BURST_FOUR: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(DQ_BUS.dqs_oe) |-> DQ_BUS.dqs_oe [*4] ##1 !DQ_BUS.dqs_oe)
        else $error("burst length not four");
    AST_STROBE_TOGGLE: assert property (@(posedge CLOCK) disable iff (RST)
        DQ_BUS.dqs_oe && $past(DQ_BUS.dqs_oe) |-> DQ_BUS.dqs_t != $past(DQ_BUS.dqs_t))
        else $error("strobe did not toggle");
    AST_LATER_BEATS_ZERO: assert property (@(posedge CLOCK) disable iff (RST)
        DQ_BUS.dqs_oe && !DQ_BUS.dqs_t && kind_q == K_NORMAL |-> DQ_BUS.dq == 32'h0000_0000)
        else $error("later beat not filler");
    AST_CAL_LANES: assert property (@(posedge CLOCK) disable iff (RST)
        DQ_BUS.dqs_oe && kind_q == K_CAL_A |-> DQ_BUS.dq[8] == DQ_BUS.dq[0])
        else $error("calibration lanes differ");
    AST_CAL_A_PATTERN: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(DQ_BUS.dqs_oe) && kind_q == K_CAL_A |-> DQ_BUS.dq[0] ##1 !DQ_BUS.dq[0]
        ##1 DQ_BUS.dq[0] ##1 !DQ_BUS.dq[0]) else $error("pattern a wrong");
    AST_EXIT_NO_CMD: assert property (@(posedge CLOCK) disable iff (RST)
        pwr_q != ST_AWAKE |-> !cmd_take) else $error("command taken outside awake");
    // exit interval neither cut short nor stretched
    AST_EXIT_LENGTH: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(pwr_q == ST_AWAKE) |-> $past(pwr_q == ST_EXIT, XSR_HOLD)
        && $past(pwr_q == ST_SREF, XSR_CYC)) else $error("exit interval length wrong");
    AST_MASK_WRITE: assert property (@(posedge CLOCK) disable iff (RST)
        mrw_go && ma == MA_BANK_MASK |=> bank_mask_q == $past(CMD.ca_f[5:2]))
        else $error("bank mask not written");
    AST_MASKED_BANK: assert property (@(posedge CLOCK) disable iff (RST)
        bank_mask_q[0] && $stable(bank_mask_q) |-> REFRESH_EN[7:0] == 8'h00)
        else $error("masked bank refreshed");
endmodule : sdm_mode_read_sref
`default_nettype wire

// >>> hw/sdm_pkg.sv
// shared constants, encodings and carrier types for the register read and self-refresh block
`default_nettype none
package sdm_pkg;
    // clock and timing
    localparam int CLK_MHZ = 100;
    localparam int RL_DEFAULT = 3;
    localparam int BURST_LEN = 4;
    localparam int REG_READ_PERIOD_CYC = 2;
    localparam int XSR_NS = 140;
    localparam int XSR_CYC = ((XSR_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
        (XSR_NS * CLK_MHZ + 999) / 1000;
    localparam int TSI_MS = 32;
    localparam int TSI_CYC = TSI_MS * CLK_MHZ * 1000;
    // command codes on ca_r at the rising edge
    localparam logic [3:0] CMD_MRR = 4'h8;
    localparam logic [3:0] CMD_MRW = 4'h0;
    localparam logic [2:0] CMD_SREF = 3'h4;
    // mode register addresses
    localparam logic [7:0] MA_TEMP = 8'h04;
    localparam logic [7:0] MA_BANK_MASK = 8'h10;
    localparam logic [7:0] MA_SEG_MASK = 8'h11;
    localparam logic [7:0] MA_CAL_A = 8'h20;
    localparam logic [7:0] MA_CAL_B = 8'h28;
    // calibration patterns, bit n is bit time n
    localparam logic [3:0] CAL_A_PAT = 4'h5;
    localparam logic [3:0] CAL_B_PAT = 4'hC;
    // bus register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASKS = 8'h08;
    localparam int CTRL_FILL_BIT = 0;
    localparam logic CTRL_FILL_RESET = 1'b1;
    localparam logic [3:0] BANK_MASK_RESET = 4'h0;
    localparam logic [7:0] SEG_MASK_RESET = 8'h00;
    localparam logic [2:0] TEMP_RESET = 3'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {ST_AWAKE, ST_SREF, ST_EXIT} sdm_pwr_t;
    typedef enum logic [1:0] {K_NORMAL, K_RSVD, K_CAL_A, K_CAL_B} sdm_kind_t;

    // command/address pins; ca_f is the falling-edge half of the same clock
    typedef struct packed {
        logic cs_n;
        logic cke;
        logic [9:0] ca_r;
        logic [9:0] ca_f;
    } sdm_ca_t;

    // data pins towards the controller
    typedef struct packed {
        logic [31:0] dq;
        logic [3:0] dq_oe;
        logic dqs_t;
        logic dqs_c;
        logic dqs_oe;
    } sdm_dq_t;
endpackage : sdm_pkg
`default_nettype wire

// >>> hw/sdm_temp_sampler.sv
// temperature status sampler: periodic and forced refresh of the status code
`default_nettype none
module sdm_temp_sampler
    import sdm_pkg::*;
#(
    parameter int TSI_CYCLES = TSI_CYC
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic force_sample,
    input wire logic [2:0] sensor,
    output logic [2:0] temp_code
);
    logic [31:0] cnt_q, cnt_d;
    logic [2:0] temp_q, temp_d;
    logic tick;

    // divider tick; a forced sample restarts the interval so age stays bounded
    always_comb
    begin
        tick = (cnt_q == 32'(TSI_CYCLES - 1)) || force_sample;
        cnt_d = tick ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
        temp_d = tick ? sensor : temp_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= 32'h0000_0000;
            temp_q <= TEMP_RESET;
        end
        else
        begin
            cnt_q <= cnt_d;
            temp_q <= temp_d;
        end
    end

    assign temp_code = temp_q;

    AST_TEMP_FRESH: assert property (@(posedge clk) disable iff (rst)
        cnt_q < 32'(TSI_CYCLES)) else $error("temperature sample older than interval");
endmodule : sdm_temp_sampler
`default_nettype wire

// >>> tb/sdm_ctl_model.sv
// memory controller model driving the command/address pins of the device
`default_nettype none
module sdm_ctl_model
    import sdm_pkg::*;
(
    input wire logic clk,
    output var sdm_ca_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle is a nop with clock-enable high; no bank is ever opened here, so
    // self-refresh entry and calibration reads always find all banks idle
    initial
    begin
        cmd = '{cs_n: 1'b1, cke: 1'b1, ca_r: 10'h0, ca_f: 10'h0};
    end

    // no array reads or writes are issued, so a register read only needs its own burst to end before the next command
    // one command edge, then a nop edge with random ca so the chip select is what matters
    task automatic issue(input logic ke, input logic [9:0] r, input logic [9:0] f);
        @(posedge clk);
        cmd <= '{cs_n: 1'b0, cke: ke, ca_r: r, ca_f: f};
        @(posedge clk);
        cmd <= '{cs_n: 1'b1, cke: ke, ca_r: 10'($urandom), ca_f: 10'($urandom)};
    endtask : issue

    // register read: address is falling ca1:ca0 above rising ca9:ca4
    task automatic mrr(input logic [7:0] a);
        issue(1'b1, {a[5:0], 4'h8}, {8'h00, a[7:6]});
    endtask : mrr

    // callers leave a full burst plus margin after any read before this
    task automatic mrw(input logic [7:0] a, input logic [7:0] d);
        issue(1'b1, {a[5:0], 4'h0}, {d, a[7:6]});
    endtask : mrw

    task automatic sref_in;
        issue(1'b0, 10'h004, 10'h000);
    endtask : sref_in

    // the clock never stops here, so two stable clocks precede the rising enable
    task automatic sref_out(input int nop_cyc);
        repeat (2) @(posedge clk);
        cmd.cke <= 1'b1;
        repeat (nop_cyc) @(posedge clk);
    endtask : sref_out
endmodule : sdm_ctl_model
`default_nettype wire

// >>> tb/tb.sv
// testbench for the register read, calibration and self-refresh block
`default_nettype none
module tb
    import sdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int RLT = 3;
    logic clk;
    logic rst;
    sdm_ca_t cmd;
    sdm_dq_t dq_bus;
    logic [31:0] refresh_en;
    logic [2:0] temp_sense;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic fill;
    int n_mismatch = 0;
    int checked = 0;

    sdm_ctl_model u_ctl (.clk(clk), .cmd(cmd));

    // short sensor interval keeps temperature polls within a few hundred cycles
    sdm_mode_read_sref #(.RL(RLT), .LANES(4), .TSI_CYCLES(64)) u_dut (
        .CLOCK(clk), .RST(rst), .CMD(cmd), .DQ_BUS(dq_bus), .REFRESH_EN(refresh_en),
        .TEMP_SENSE(temp_sense), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        $display("counts: checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // a hang in any handshake wait ends up here
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // single word transfer: hold address phase until ready, then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, exp);
        chk(32'(hresp), 32'h0);
    endtask : rd_chk

    // pattern bits: bit n of the nibble is bit time n
    function automatic logic [31:0] exp_dq(input logic [7:0] a, input logic [7:0] v,
                                           input int b, input logic f);
        logic p;
        if (a == 8'h20 || a == 8'h28)
        begin
            p = 1'(((a == 8'h20) ? 4'h5 : 4'hc) >> b);
            return f ? {32{p}} : {4{7'h00, p}};
        end
        return (b == 0) ? {24'h0, v} : 32'h0;
    endfunction : exp_dq

    function automatic logic [31:0] exp_ref(input logic [3:0] bm, input logic [7:0] sm);
        logic [31:0] e;
        for (int i = 0; i < 32; i++)
            e[i] = ~bm[i / 8] & ~sm[i % 8];
        return e;
    endfunction : exp_ref

    // one register read: latency, four beats with toggling strobes, then release
    task automatic mr_chk(input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        u_ctl.mrr(a);
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (dq_bus.dqs_oe !== 1'b1 && n < 12);
        // pins seen just after edge k+rl-1 are what the controller samples at edge k+rl
        chk(32'(n), 32'(RLT - 1));
        for (int b = 0; b < 4; b++)
        begin
            chk(dq_bus.dq, exp_dq(a, v, b, fill));
            chk(32'({dq_bus.dqs_t, dq_bus.dqs_c, dq_bus.dq_oe}), 32'({~b[0], b[0], 4'hf}));
            @(posedge clk);
            #1;
        end
        chk(32'(dq_bus.dqs_oe), 32'h0);
    endtask : mr_chk

    initial
    begin
        logic [31:0] r;
        logic [3:0] bm;
        logic [7:0] sm;
        logic [7:0] ra;
        logic [2:0] t;
        logic seen;
        rst = 1'b1;
        temp_sense = 3'h3;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fill = 1'b1;
        t = 3'h3;
        r = $urandom(32'h0000_1d0f);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        // reset values, read-only status and an unmapped word
        rd_chk(OFS_CTRL, 32'h1);
        rd_chk(OFS_STATUS, 32'h30);
        rd_chk(OFS_MASKS, 32'h0);
        rd_chk(8'h0c, 32'h0);
        ahb(1'b1, OFS_STATUS, 32'hffff_ffff, r);
        rd_chk(OFS_STATUS, 32'h30);
        $display("test registers done");
        // random masks, fill choice, temperature and every kind of register read
        for (int i = 0; i < 6; i++)
        begin
            bm = 4'($urandom);
            sm = 8'($urandom);
            t = 3'($urandom);
            ra = 8'($urandom);
            if (ra inside {8'h04, 8'h10, 8'h11, 8'h20, 8'h28})
                ra = 8'h3f;
            // first pass forces zero fill so the zero-fill lane choice is always seen; later passes pick fill at random
            fill = (i == 0) ? 1'b0 : 1'($urandom);
            @(posedge clk);
            temp_sense <= t;
            ahb(1'b1, OFS_CTRL, {31'h0, fill}, r);
            u_ctl.mrw(MA_BANK_MASK, {4'($urandom), bm});
            u_ctl.mrw(MA_SEG_MASK, sm);
            rd_chk(OFS_MASKS, {16'h0, sm, 4'h0, bm});
            mr_chk(MA_BANK_MASK, {4'h0, bm});
            mr_chk(MA_SEG_MASK, sm);
            mr_chk(MA_CAL_A, 8'h00);
            mr_chk(MA_CAL_B, 8'h00);
            mr_chk(ra, 8'h00);
            // wait one full sensor interval plus margin before polling
            repeat (70) @(posedge clk);
            mr_chk(MA_TEMP, {5'h0, t});
            rd_chk(OFS_STATUS, {25'h0, t, 4'h0});
        end
        $display("test register reads done");
        // self-refresh with masks, new temperature at exit, refused read during exit
        u_ctl.sref_in();
        repeat (3) @(posedge clk);
        #1 chk(refresh_en, exp_ref(bm, sm));
        rd_chk(OFS_STATUS, {25'h0, t, 4'h1});
        t = 3'($urandom);
        temp_sense <= t;
        u_ctl.sref_out(3);
        rd_chk(OFS_STATUS, {25'h0, t, 4'h2});
        u_ctl.mrr(MA_TEMP);
        seen = 1'b0;
        repeat (RLT + 4)
        begin
            @(posedge clk);
            #1 seen = seen | dq_bus.dqs_oe;
        end
        chk(32'(seen), 32'h0);
        repeat (14) @(posedge clk);
        mr_chk(MA_TEMP, {5'h0, t});
        chk(refresh_en, 32'h0);
        $display("test self-refresh done");
        test_done();
    end
endmodule : tb
`default_nettype wire
